/* File: shared/swdh_pkg.sv */
// constants and types shared by both ends of the single-wire debug link
package swdh_pkg;
	// ----------------------------------------------------------------
	// timing, counted in serial clock cycles
	// ----------------------------------------------------------------
	localparam int unsigned SER_DIV      = 8;
	localparam logic [2:0]  SER_DIV_LAST = 3'h7;
	localparam logic [9:0]  SYNC_DETECT  = 10'h080;
	localparam logic [9:0]  SYNC_DELAY   = 10'h010;
	localparam logic [9:0]  SYNC_LOW     = 10'h080;
	localparam logic [9:0]  ACK_LOW      = 10'h010;
	localparam logic [9:0]  TIMEOUT      = 10'h200;
	localparam logic [9:0]  CNT_ONE      = 10'h001;
	localparam logic [9:0]  CNT_ZERO     = 10'h000;

	// ----------------------------------------------------------------
	// command classes reported by the command decoder
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SWDH_CMD_ACK_ON,
		SWDH_CMD_ACK_OFF,
		SWDH_CMD_READ,
		SWDH_CMD_WRITE,
		SWDH_CMD_HALT,
		SWDH_CMD_RESUME,
		SWDH_CMD_RESUME_UNTIL,
		SWDH_CMD_STEP
	} swdh_cmd_e;

	// ----------------------------------------------------------------
	// serial tick test
	// ----------------------------------------------------------------
	function automatic logic swdh_tick(input logic [2:0] div);
		return div == SER_DIV_LAST;
	endfunction : swdh_tick
endpackage : swdh_pkg

/* File: shared/swdh_link_if.sv */
// debug pin wire between host and target ends
interface swdh_link_if;
	logic host_out;
	logic host_oe;
	logic tgt_out;
	logic tgt_oe;
	logic debug_pin;

	// pulled high; low wins when any driver pulls low
	assign debug_pin = !((host_oe && !host_out) || (tgt_oe && !tgt_out));

	modport target (input debug_pin, output tgt_out, output tgt_oe);
	modport host   (input debug_pin, output host_out, output host_oe);
endinterface : swdh_link_if

/* File: design/swdh_target.sv */
// target end: handshake acks, sync answer, serial time-out, stepping
module swdh_target
	import swdh_pkg::*;
(
	// clock and reset
	input  wire logic    clk,
	input  wire logic    resetn,
	// debug pin
	swdh_link_if.target  link,
	// command decoder events
	input  wire logic    cmd_valid,
	input  wire swdh_cmd_e cmd_kind,
	input  wire logic    xfer_busy,
	input  wire logic    read_pending,
	// cpu status
	input  wire logic    cpu_enter_bg,
	input  wire logic    cpu_leave_bg,
	input  wire logic    cpu_low_power,
	input  wire logic    sys_stop,
	input  wire logic    int_pending,
	// results
	output logic         ack_enabled,
	output logic         soft_reset,
	output logic         fall_edge,
	output logic         step_go,
	output logic         step_stack_only,
	output logic         cmd_ignored
);
	typedef enum {ST_IDLE, ST_LOWCNT, ST_WAIT_HIGH, ST_SYNC_DLY, ST_SYNC_LOW,
		ST_SYNC_SPD, ST_ACK_LOW, ST_ACK_SPD} swdh_state_e;
	typedef enum {AK_NONE, AK_NOW, AK_ENTER, AK_LEAVE} swdh_ack_e;

	// ----------------------------------------------------------------
	// serial clock divider and pin edges
	// ----------------------------------------------------------------
	logic [2:0] div_reg;
	logic [2:0] div_next;
	logic       pin_prev_reg;
	logic       tick;
	logic       fall;
	logic       rise;

	// divide core clock by eight for the serial clock
	always_comb
	begin
		div_next = div_reg + 3'h1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_reg      <= 3'h0;
			pin_prev_reg <= 1'b1;
		end
		else
		begin
			div_reg      <= div_next;
			pin_prev_reg <= link.debug_pin;
		end
	end

	assign tick = swdh_tick(div_reg);
	assign fall = pin_prev_reg && !link.debug_pin && !link.tgt_oe;
	assign rise = !pin_prev_reg && link.debug_pin;

	// ----------------------------------------------------------------
	// pin state machine: sync detect, sync answer, ack pulse
	// ----------------------------------------------------------------
	swdh_state_e st_reg;
	swdh_state_e st_next;
	logic [9:0]  cnt_reg;
	logic [9:0]  cnt_next;
	logic        sync_hit;
	logic        ack_fire;
	logic        ack_sent;

	always_comb
	begin
		st_next  = st_reg;
		cnt_next = tick ? cnt_reg + CNT_ONE : cnt_reg;
		sync_hit = 1'b0;
		ack_sent = 1'b0;
		case (st_reg)
			ST_IDLE:
			begin
				cnt_next = CNT_ZERO;
				if (fall)
					st_next = ST_LOWCNT;
				else if (ack_fire && link.debug_pin && tick)
					st_next = ST_ACK_LOW; // start on a tick so the low is whole periods
			end
			ST_LOWCNT:
			begin
				if (link.debug_pin)
					st_next = ST_IDLE;
				else if (cnt_reg > SYNC_DETECT)
				begin
					sync_hit = 1'b1;
					st_next  = ST_WAIT_HIGH;
				end
			end
			ST_WAIT_HIGH:
			begin
				cnt_next = CNT_ZERO;
				if (link.debug_pin)
					st_next = ST_SYNC_DLY;
			end
			ST_SYNC_DLY:
			begin
				if (tick && cnt_reg == SYNC_DELAY - CNT_ONE)
				begin
					cnt_next = CNT_ZERO;
					st_next  = ST_SYNC_LOW;
				end
			end
			ST_SYNC_LOW:
			begin
				if (tick && cnt_reg == SYNC_LOW - CNT_ONE)
				begin
					cnt_next = CNT_ZERO;
					st_next  = ST_SYNC_SPD;
				end
			end
			ST_SYNC_SPD, ST_ACK_SPD:
			begin
				// one whole serial period of driven high
				if (tick)
					st_next = ST_IDLE;
			end
			ST_ACK_LOW:
			begin
				if (tick && cnt_reg == ACK_LOW - CNT_ONE)
				begin
					cnt_next = CNT_ZERO;
					ack_sent = 1'b1;
					st_next  = ST_ACK_SPD;
				end
			end
			default:
				st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg  <= ST_IDLE;
			cnt_reg <= CNT_ZERO;
		end
		else
		begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
		end
	end

	// pin drive: low phases then a driven speedup high
	assign link.tgt_oe  = st_reg inside {ST_SYNC_LOW, ST_SYNC_SPD, ST_ACK_LOW, ST_ACK_SPD};
	assign link.tgt_out = st_reg inside {ST_SYNC_SPD, ST_ACK_SPD};

	// ----------------------------------------------------------------
	// handshake enable and pending acknowledge
	// ----------------------------------------------------------------
	logic      en_reg;
	logic      en_next;
	swdh_ack_e ak_reg;
	swdh_ack_e ak_next;
	logic      ak_step_reg;
	logic      ak_step_next;
	logic      accept;

	// halt is dead in low power, nothing works in system stop
	assign accept = cmd_valid && !sys_stop
		&& !(cpu_low_power && cmd_kind == SWDH_CMD_HALT);
	assign ack_fire = en_reg && ak_reg == AK_NOW;

	always_comb
	begin
		en_next      = en_reg;
		ak_next      = ak_reg;
		ak_step_next = ak_step_reg;
		// cpu events move a waiting ack to the send stage
		if (ak_reg == AK_ENTER && cpu_enter_bg)
			ak_next = AK_NOW;
		if (ak_reg == AK_LEAVE && cpu_leave_bg)
			ak_next = AK_NOW;
		if (ak_step_reg && cpu_low_power)
		begin
			ak_next      = AK_NONE;
			ak_step_next = 1'b0;
		end
		if (ack_sent)
		begin
			ak_next      = AK_NONE;
			ak_step_next = 1'b0;
		end
		if (accept)
		begin
			ak_step_next = 1'b0;
			case (cmd_kind)
				SWDH_CMD_ACK_ON:
				begin
					en_next = 1'b1;
					ak_next = AK_NOW;
				end
				SWDH_CMD_ACK_OFF:
				begin
					en_next = 1'b0;
					ak_next = AK_NONE;
				end
				SWDH_CMD_READ:         ak_next = AK_NOW;
				SWDH_CMD_WRITE:        ak_next = AK_NOW;
				SWDH_CMD_HALT:         ak_next = AK_ENTER;
				SWDH_CMD_RESUME:       ak_next = AK_LEAVE;
				SWDH_CMD_RESUME_UNTIL: ak_next = AK_ENTER;
				SWDH_CMD_STEP:
				begin
					ak_next      = AK_ENTER;
					ak_step_next = 1'b1;
				end
				default:               ak_next = AK_NONE;
			endcase
		end
		if (sync_hit)
		begin
			ak_next      = AK_NONE;
			ak_step_next = 1'b0;
		end
		if (!en_next)
			ak_next = AK_NONE;
		if (sys_stop)
			en_next = 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			en_reg      <= 1'b0;
			ak_reg      <= AK_NONE;
			ak_step_reg <= 1'b0;
		end
		else
		begin
			en_reg      <= en_next;
			ak_reg      <= ak_next;
			ak_step_reg <= ak_step_next;
		end
	end

	// ----------------------------------------------------------------
	// serial time-out and read data expiry
	// ----------------------------------------------------------------
	logic [9:0] to_reg;
	logic [9:0] to_next;
	logic       rd_ack_reg;
	logic       rd_ack_next;
	logic       to_hold;
	logic       to_hit;

	// read data waits for its ack without expiring while acks are enabled
	assign to_hold = read_pending && en_reg && !rd_ack_reg;
	assign to_hit  = to_reg == TIMEOUT;

	always_comb
	begin
		rd_ack_next = read_pending && (rd_ack_reg || ack_sent);
		to_next     = to_reg;
		if (fall || !(xfer_busy || read_pending) || to_hold || to_hit)
			to_next = CNT_ZERO;
		else if (tick)
			to_next = to_reg + CNT_ONE;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			to_reg     <= CNT_ZERO;
			rd_ack_reg <= 1'b0;
		end
		else
		begin
			to_reg     <= to_next;
			rd_ack_reg <= rd_ack_next;
		end
	end

	// ----------------------------------------------------------------
	// registered result strobes
	// ----------------------------------------------------------------
	logic sr_next;
	logic sg_next;
	logic ss_next;
	logic ci_next;

	always_comb
	begin
		sr_next = sync_hit || to_hit;
		sg_next = accept && cmd_kind == SWDH_CMD_STEP && !int_pending;
		ss_next = accept && cmd_kind == SWDH_CMD_STEP && int_pending;
		ci_next = cmd_valid && !accept;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			soft_reset      <= 1'b0;
			fall_edge       <= 1'b0;
			step_go         <= 1'b0;
			step_stack_only <= 1'b0;
			cmd_ignored     <= 1'b0;
			ack_enabled     <= 1'b0;
		end
		else
		begin
			soft_reset      <= sr_next;
			fall_edge       <= fall && st_reg == ST_IDLE;
			step_go         <= sg_next;
			step_stack_only <= ss_next;
			cmd_ignored     <= ci_next;
			ack_enabled     <= en_next;
		end
	end
endmodule : swdh_target

/* File: design/swdh_host.sv */
// host end: sync request, sync response measure, ack detection
module swdh_host
	import swdh_pkg::*;
#(
	parameter int unsigned SYNC_REQ_CLK = 4096
)
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  resetn,
	// debug pin
	swdh_link_if.host  link,
	// user side
	input  wire logic  sync_start,
	input  wire logic  bit_low,
	output logic       busy,
	output logic       ack_seen,
	output logic [15:0] sync_len,
	output logic       sync_len_valid
);
	typedef enum {H_IDLE, H_REQ_LOW, H_REQ_SPD, H_LISTEN, H_MEAS} swdh_hstate_e;

	// ----------------------------------------------------------------
	// sync request and response measurement
	// ----------------------------------------------------------------
	swdh_hstate_e st_reg;
	swdh_hstate_e st_next;
	logic [15:0]  cnt_reg;
	logic [15:0]  cnt_next;
	logic         pin_prev_reg;
	logic         fall;
	logic         len_v_next;
	logic [15:0]  len_next;
	logic         ack_next;

	assign fall = pin_prev_reg && !link.debug_pin;

	always_comb
	begin
		st_next    = st_reg;
		cnt_next   = cnt_reg + 16'h0001;
		len_next   = sync_len;
		len_v_next = 1'b0;
		ack_next   = 1'b0;
		case (st_reg)
			H_IDLE:
			begin
				cnt_next = 16'h0000;
				if (sync_start)
					st_next = H_REQ_LOW;
				else if (fall && !bit_low)
					ack_next = 1'b1;
			end
			H_REQ_LOW:
			begin
				// held for the slowest serial clock
				if (cnt_reg == 16'(SYNC_REQ_CLK - 1))
					st_next = H_REQ_SPD;
			end
			H_REQ_SPD:
				st_next = H_LISTEN;
			H_LISTEN:
			begin
				cnt_next = 16'h0000;
				if (fall)
					st_next = H_MEAS;
			end
			H_MEAS:
			begin
				if (link.debug_pin)
				begin
					len_next   = cnt_reg;
					len_v_next = 1'b1;
					st_next    = H_IDLE;
				end
			end
			default:
				st_next = H_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg         <= H_IDLE;
			cnt_reg        <= 16'h0000;
			pin_prev_reg   <= 1'b1;
			sync_len       <= 16'h0000;
			sync_len_valid <= 1'b0;
			ack_seen       <= 1'b0;
		end
		else
		begin
			st_reg         <= st_next;
			cnt_reg        <= cnt_next;
			pin_prev_reg   <= link.debug_pin;
			sync_len       <= len_next;
			sync_len_valid <= len_v_next;
			ack_seen       <= ack_next;
		end
	end

	// drive low during request and bit lows; the request ends in a driven speedup
	assign link.host_oe  = st_reg == H_REQ_LOW || st_reg == H_REQ_SPD
		|| (st_reg == H_IDLE && bit_low);
	assign link.host_out = st_reg == H_REQ_SPD;
	assign busy          = st_reg != H_IDLE;
endmodule : swdh_host

/* File: test/swdh_assertions.sv */
// checker on the shared debug pin between both ends
module swdh_assertions
	import swdh_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// wire signals
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic tgt_out,
	input wire logic tgt_oe,
	input wire logic debug_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// run-length helpers
	// ----------------------------------------------------------------
	wire logic   t_lo = tgt_oe && !tgt_out;
	logic [10:0] lo_reg;
	logic [10:0] lo_next;
	logic [10:0] hi_reg;
	logic [10:0] hi_next;
	logic [10:0] pl_reg;
	logic [10:0] pl_next;
	logic        sync_reg;
	logic        sync_next;
	// target low run, pin high run, pin low run, long request seen
	always_comb
	begin
		lo_next = t_lo ? lo_reg + 11'h001 : 11'h000;
		hi_next = debug_pin ? hi_reg + {10'h000, hi_reg != 11'h7ff} : 11'h000;
		pl_next = debug_pin ? 11'h000 : pl_reg + {10'h000, pl_reg != 11'h7ff};
		sync_next = (pl_reg == 11'h41a) || (sync_reg && (t_lo || lo_reg == 11'h000));
	end
	// registers only
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lo_reg <= 11'h000;
			hi_reg <= 11'h000;
			pl_reg <= 11'h000;
			sync_reg <= 1'b0;
		end
		else
		begin
			lo_reg <= lo_next;
			hi_reg <= hi_next;
			pl_reg <= pl_next;
			sync_reg <= sync_next;
		end
	end
	// ----------------------------------------------------------------
	// wire properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	property p_idle; $rose(resetn) |-> !tgt_oe && !host_oe; endproperty
	a_idle: assert property (p_idle) else $error("pin driven at reset exit");
	property p_clash; !(host_oe && tgt_oe); endproperty
	a_clash: assert property (p_clash) else $error("both ends drive");
	property p_start; $rose(tgt_oe) |-> $past(debug_pin); endproperty
	a_start: assert property (p_start) else $error("target drove low pin");
	property p_len; !t_lo && lo_reg != 11'h000 |-> lo_reg inside {[127:129], [1023:1025]}; endproperty
	a_len: assert property (p_len) else $error("target low length");
	property p_resp; !t_lo && lo_reg != 11'h000 && sync_reg |-> lo_reg inside {[1023:1025]}; endproperty
	a_resp: assert property (p_resp) else $error("sync answer length");
	property p_delay; $rose(tgt_oe) && sync_reg |-> hi_reg >= 11'h078; endproperty
	a_delay: assert property (p_delay) else $error("sync answer too early");
	property p_spd; $past(t_lo) && !t_lo |-> tgt_oe && tgt_out; endproperty
	a_spd: assert property (p_spd) else $error("no target speedup");
	property p_spd_end; tgt_oe && tgt_out |-> ##[1:10] !tgt_oe; endproperty
	a_spd_end: assert property (p_spd_end) else $error("target speedup long");
	property p_hspd; host_oe && host_out |=> !host_oe; endproperty
	a_hspd: assert property (p_hspd) else $error("host speedup long");
endmodule : swdh_assertions

/* File: test/single_wire_debug_handshake_tb.sv */
// self-checking bench joining host and target ends
module single_wire_debug_handshake_tb;
	import swdh_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int unsigned REQ = 1100;
	localparam int ACK = 0, SR = 1, FE = 2, GO = 3, SO = 4, IG = 5, SV = 6;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        cmd_valid, xfer_busy, read_pending, cpu_enter_bg, cpu_leave_bg;
	logic        cpu_low_power, sys_stop, int_pending, sync_start, bit_low;
	swdh_cmd_e   cmd_kind;
	logic        ack_enabled, soft_reset, fall_edge, step_go, step_stack_only, cmd_ignored;
	logic        ack_seen, busy, sync_len_valid;
	logic [15:0] sync_len;
	int          mismatches = 0;
	int          cmp_count = 0;
	wire logic [6:0] flags = {sync_len_valid, cmd_ignored, step_stack_only, step_go,
		fall_edge, soft_reset, ack_seen};
	// clock
	always #12.5 clk = !clk;
	swdh_link_if link ();
	swdh_target swdh_target_i (.clk(clk), .resetn(resetn), .link(link), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .xfer_busy(xfer_busy), .read_pending(read_pending),
		.cpu_enter_bg(cpu_enter_bg), .cpu_leave_bg(cpu_leave_bg), .cpu_low_power(cpu_low_power),
		.sys_stop(sys_stop), .int_pending(int_pending), .ack_enabled(ack_enabled),
		.soft_reset(soft_reset), .fall_edge(fall_edge), .step_go(step_go),
		.step_stack_only(step_stack_only), .cmd_ignored(cmd_ignored));
	swdh_host #(.SYNC_REQ_CLK(REQ)) swdh_host_i (.clk(clk), .resetn(resetn), .link(link),
		.sync_start(sync_start), .bit_low(bit_low), .busy(busy), .ack_seen(ack_seen),
		.sync_len(sync_len), .sync_len_valid(sync_len_valid));
	swdh_assertions swdh_assertions_i (.clk(clk), .resetn(resetn), .host_out(link.host_out),
		.host_oe(link.host_oe), .tgt_out(link.tgt_out), .tgt_oe(link.tgt_oe),
		.debug_pin(link.debug_pin));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_bit
	// measured length may land a couple of clocks off
	task automatic cmp_len(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (!(got >= exp - 16'h0002 && got <= exp + 16'h0002))
		begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_len
	// watch a flag for n cycles, clearing one-cycle inputs on the way
	task automatic see(input int b, input int n, input logic exp);
		logic hit;
		hit = 1'b0;
		while (n > 0 && !hit)
		begin
			@(negedge clk);
			cmd_valid = 1'b0;
			cpu_enter_bg = 1'b0;
			cpu_leave_bg = 1'b0;
			sync_start = 1'b0;
			hit = flags[b];
			n--;
		end
		cmp_bit(hit, exp);
	endtask : see
	task automatic send(input swdh_cmd_e k);
		@(negedge clk);
		cmd_kind = k;
		cmd_valid = 1'b1;
	endtask : send
	// which cpu event makes the ack due
	function automatic int ev(input swdh_cmd_e k);
		if (k == SWDH_CMD_RESUME)
			return 2;
		return (k == SWDH_CMD_HALT || k == SWDH_CMD_RESUME_UNTIL || k == SWDH_CMD_STEP);
	endfunction : ev
	task automatic run(input swdh_cmd_e k, input logic exp);
		send(k);
		if (k == SWDH_CMD_STEP)
			see(int_pending ? SO : GO, 3, 1'b1);
		if (ev(k) != 0)
		begin
			see(ACK, $urandom_range(20, 60), 1'b0);
			cpu_enter_bg = (ev(k) == 1);
			cpu_leave_bg = (ev(k) == 2);
		end
		see(ACK, 300, exp);
		repeat (200) @(negedge clk);
	endtask : run
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		{cmd_valid, xfer_busy, read_pending, cpu_enter_bg, cpu_leave_bg} = 5'h00;
		{cpu_low_power, sys_stop, int_pending, sync_start, bit_low} = 5'h00;
		cmd_kind = SWDH_CMD_READ;
		void'($urandom(32'h4b9d));
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		cmp_bit(ack_enabled, 1'b0);
		cmp_bit(link.debug_pin, 1'b1);
		run(SWDH_CMD_READ, 1'b0);
		$display("test reset done");
		run(SWDH_CMD_ACK_ON, 1'b1);
		cmp_bit(ack_enabled, 1'b1);
		for (int i = 0; i < 12; i++)
		begin
			int_pending = $urandom_range(0, 1);
			run(swdh_cmd_e'(i < 6 ? i + 2 : $urandom_range(2, 7)), 1'b1);
		end
		int_pending = 1'b0;
		$display("test commands done");
		send(SWDH_CMD_STEP);
		see(GO, 3, 1'b1);
		cpu_low_power = 1'b1;
		see(ACK, 40, 1'b0);
		cpu_low_power = 1'b0;
		cpu_enter_bg = 1'b1;
		see(ACK, 300, 1'b0);
		cpu_low_power = 1'b1;
		run(SWDH_CMD_WRITE, 1'b1);
		send(SWDH_CMD_HALT);
		see(IG, 3, 1'b1);
		cpu_low_power = 1'b0;
		$display("test low power done");
		send(SWDH_CMD_HALT);
		see(ACK, 30, 1'b0);
		sync_start = 1'b1;
		see(SR, REQ + 200, 1'b1);
		cmp_bit(busy, 1'b1);
		see(SV, 2000, 1'b1);
		cmp_bit(busy, 1'b0);
		cmp_len(sync_len, 16'(SYNC_LOW * SER_DIV));
		cpu_enter_bg = 1'b1;
		see(ACK, 300, 1'b0);
		$display("test sync done");
		sys_stop = 1'b1;
		send(SWDH_CMD_READ);
		see(IG, 3, 1'b1);
		cmp_bit(ack_enabled, 1'b0);
		sys_stop = 1'b0;
		run(SWDH_CMD_READ, 1'b0);
		run(SWDH_CMD_ACK_ON, 1'b1);
		send(SWDH_CMD_ACK_OFF);
		see(IG, 3, 1'b0);
		run(SWDH_CMD_WRITE, 1'b0);
		$display("test stop done");
		xfer_busy = 1'b1;
		bit_low = 1'b1;
		see(FE, 30, 1'b1);
		bit_low = 1'b0;
		see(SR, 4000, 1'b0);
		see(SR, 300, 1'b1);
		xfer_busy = 1'b0;
		read_pending = 1'b1;
		see(SR, 4000, 1'b0);
		see(SR, 300, 1'b1);
		read_pending = 1'b0;
		run(SWDH_CMD_ACK_ON, 1'b1);
		read_pending = 1'b1;
		see(SR, 4500, 1'b0);
		run(SWDH_CMD_READ, 1'b1);
		see(SR, 3700, 1'b0);
		see(SR, 500, 1'b1);
		read_pending = 1'b0;
		$display("test time-out done");
		give_verdict();
	end
	// cut a hang short
	initial
	begin
		repeat (70000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
endmodule : single_wire_debug_handshake_tb
